//--- core/asr_pkg.sv
package asr_pkg;
   localparam logic [5:0] A_STATUS = 6'h00;
   localparam logic [5:0] A_ADCMODE = 6'h01;
   localparam logic [5:0] A_IFMODE = 6'h02;
   localparam logic [5:0] A_PART = 6'h07;
   localparam logic [5:0] A_CHAN = 6'h10;
   localparam logic [5:0] A_SCON = 6'h20;
   localparam logic [5:0] A_FCON = 6'h28;
   localparam logic [5:0] A_OFFS = 6'h30;
   localparam logic [5:0] A_GAIN = 6'h38;
   localparam int CMD_GATE_BIT = 7;
   localparam int CH_ON_BIT = 15;
   localparam logic [5:0] LEN8 = 6'd8;
   localparam logic [5:0] LEN16 = 6'd16;
   localparam logic [5:0] LEN24 = 6'd24;
   localparam logic [2:0] CMD_LAST = 3'd7;
   localparam logic [6:0] RESET_ONES = 7'd64;
   localparam logic [15:0] CHAN0_RST = 16'h8001;
   localparam logic [15:0] CHAN_RST = 16'h0001;
   localparam logic [15:0] SCON_RST = 16'h1000;
   localparam logic [15:0] FCON_RST = 16'h0500;
   localparam logic [23:0] OFFS_RST = 24'h80_0000;
   localparam logic [23:0] GAIN_RST = 24'h50_0000;
   localparam logic [15:0] ADCMODE_RST = 16'h2000;
   localparam logic [15:0] IFMODE_RST = 16'h0000;
   // Arbitrary neutral part code, low nibble unused
   localparam logic [15:0] PART_CODE = 16'ha5c0;
   localparam int CONV_NS = 8000;
   localparam int MCLK_NS = 10;
   localparam int CONV_CYC = CONV_NS / MCLK_NS;
   localparam logic [9:0] CONV_LAST = 10'(CONV_CYC - 1);
   typedef struct packed {
      logic rd;
      logic [5:0] addr;
   } asr_cmd_s;
   typedef enum {ASR_CMD, ASR_DATA} asr_phase_e;
endpackage : asr_pkg

//--- core/asr_serial_regs.sv
module asr_serial_regs
(
   // Device clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Serial link
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   output logic dout,
   output logic dout_oe,
   // Sequencer
   output logic [3:0] active_channel,
   output logic conv_strobe
);
   import asr_pkg::*;

   logic [15:0] chan_reg [16];
   logic [15:0] scon_reg [8];
   logic [15:0] fcon_reg [8];
   logic [23:0] offs_reg [8];
   logic [23:0] gain_reg [8];
   logic [15:0] adcmode_reg;
   logic [15:0] ifmode_reg;
   asr_phase_e phase_reg;
   asr_cmd_s cmd_reg;
   logic [5:0] cnt_reg;
   logic [23:0] rx_reg;
   logic [31:0] tx_reg;
   logic [6:0] ones_reg;
   logic dout_reg;
   logic oe_reg;
   logic [3:0] seen_chan_reg;
   logic tg_s1_reg;
   logic tg_s2_reg;
   logic tg_s3_reg;
   logic [15:0] on_s1_reg;
   logic [15:0] on_s2_reg;
   logic [3:0] act_reg;
   logic [3:0] act_next;
   logic tgl_reg;
   logic [9:0] conv_cnt_reg;
   logic strobe_reg;
   logic [15:0] chan_on;

   // Frame state is cleared by chip select going high
   wire frst_n = resetn & ~cs_n;

   // Command byte as it completes on this edge
   wire [7:0] cmd_byte = {rx_reg[6:0], din};
   wire in_cmd = (phase_reg == ASR_CMD);
   wire cmd_done = in_cmd & (cnt_reg[2:0] == CMD_LAST);
   wire cmd_ok = cmd_done & ~cmd_byte[CMD_GATE_BIT];
   wire [5:0] a_sel = in_cmd ? cmd_byte[5:0] : cmd_reg.addr;

   // Data width of the addressed register
   wire is_16 = (a_sel == A_ADCMODE) | (a_sel == A_IFMODE) |
                (a_sel == A_PART) | (a_sel[5:4] == 2'b01) |
                (a_sel[5:4] == 2'b10);
   wire is_24 = (a_sel[5:4] == 2'b11);
   wire [5:0] len_sel = is_24 ? LEN24 : (is_16 ? LEN16 : LEN8);

   // Read selection
   wire [23:0] rd_val =
      (a_sel == A_STATUS) ? {20'h0_0000, seen_chan_reg} :
      (a_sel == A_ADCMODE) ? {8'h00, adcmode_reg} :
      (a_sel == A_IFMODE) ? {8'h00, ifmode_reg} :
      (a_sel == A_PART) ? {8'h00, PART_CODE} :
      (a_sel[5:4] == 2'b01) ? {8'h00, chan_reg[a_sel[3:0]]} :
      (a_sel[5:3] == 3'b100) ? {8'h00, scon_reg[a_sel[2:0]]} :
      (a_sel[5:3] == 3'b101) ? {8'h00, fcon_reg[a_sel[2:0]]} :
      (a_sel[5:3] == 3'b110) ? offs_reg[a_sel[2:0]] :
      (a_sel[5:3] == 3'b111) ? gain_reg[a_sel[2:0]] : 24'h00_0000;

   // Left-aligned so the MSB leaves first
   wire [31:0] tx_load =
      (len_sel == LEN8) ? {rd_val[7:0], 24'h00_0000} :
      (len_sel == LEN16) ? {rd_val[15:0], 16'h0000} :
      {rd_val, 8'h00};

   wire data_last = ~in_cmd & (cnt_reg == len_sel - 6'd1);
   wire wr_fire = data_last & ~cmd_reg.rd;
   wire [23:0] wdata = {rx_reg[22:0], din};
   wire [5:0] wa = cmd_reg.addr;

   // Long run of ones on the data line
   wire hit = din & (ones_reg == RESET_ONES - 7'd1);

   always_ff @(posedge sclk or negedge frst_n)
   begin
      if (!frst_n)
      begin
         ones_reg <= 7'd0;
      end
      else if (!din)
      begin
         ones_reg <= 7'd0;
      end
      else if (ones_reg != RESET_ONES)
      begin
         ones_reg <= ones_reg + 7'd1;
      end
   end

   // Bits are captured on the rising edge
   always_ff @(posedge sclk or negedge frst_n)
   begin
      if (!frst_n)
      begin
         rx_reg <= 24'h00_0000;
      end
      else
      begin
         rx_reg <= wdata;
      end
   end

   always_ff @(posedge sclk or negedge frst_n)
   begin
      if (!frst_n)
      begin
         phase_reg <= ASR_CMD;
         cnt_reg <= 6'd0;
         cmd_reg <= '0;
         tx_reg <= 32'h0000_0000;
      end
      else if (hit)
      begin
         phase_reg <= ASR_CMD;
         cnt_reg <= 6'd0;
         tx_reg <= 32'h0000_0000;
      end
      else if (in_cmd)
      begin
         if (cmd_ok)
         begin
            phase_reg <= ASR_DATA;
            cmd_reg <= cmd_byte[6:0];
            cnt_reg <= 6'd0;
            tx_reg <= cmd_byte[6] ? tx_load : 32'h0000_0000;
         end
         else if (cmd_done)
         begin
            cnt_reg <= 6'd0;
         end
         else
         begin
            cnt_reg <= cnt_reg + 6'd1;
         end
      end
      else if (data_last)
      begin
         phase_reg <= ASR_CMD;
         cnt_reg <= 6'd0;
         tx_reg <= 32'h0000_0000;
      end
      else
      begin
         cnt_reg <= cnt_reg + 6'd1;
         tx_reg <= {tx_reg[30:0], 1'b0};
      end
   end

   // Output bits change on the falling edge
   always_ff @(negedge sclk or negedge frst_n)
   begin
      if (!frst_n)
      begin
         dout_reg <= 1'b0;
         oe_reg <= 1'b0;
      end
      else
      begin
         dout_reg <= tx_reg[31];
         oe_reg <= (phase_reg == ASR_DATA) & cmd_reg.rd;
      end
   end

   assign dout = dout_reg;
   assign dout_oe = oe_reg & ~cs_n;

   // Configuration registers
   always_ff @(posedge sclk or negedge resetn)
   begin
      if (!resetn)
      begin
         for (int i = 0; i < 16; i++)
         begin
            chan_reg[i] <= (i == 0) ? CHAN0_RST : CHAN_RST;
         end
         for (int i = 0; i < 8; i++)
         begin
            scon_reg[i] <= SCON_RST;
            fcon_reg[i] <= FCON_RST;
            offs_reg[i] <= OFFS_RST;
            gain_reg[i] <= GAIN_RST;
         end
         adcmode_reg <= ADCMODE_RST;
         ifmode_reg <= IFMODE_RST;
      end
      else if (hit)
      begin
         for (int i = 0; i < 16; i++)
         begin
            chan_reg[i] <= (i == 0) ? CHAN0_RST : CHAN_RST;
         end
         for (int i = 0; i < 8; i++)
         begin
            scon_reg[i] <= SCON_RST;
            fcon_reg[i] <= FCON_RST;
            offs_reg[i] <= OFFS_RST;
            gain_reg[i] <= GAIN_RST;
         end
         adcmode_reg <= ADCMODE_RST;
         ifmode_reg <= IFMODE_RST;
      end
      else if (wr_fire)
      begin
         if (wa == A_ADCMODE)
         begin
            adcmode_reg <= wdata[15:0];
         end
         if (wa == A_IFMODE)
         begin
            ifmode_reg <= wdata[15:0];
         end
         if (wa[5:4] == 2'b01)
         begin
            chan_reg[wa[3:0]] <= wdata[15:0];
         end
         if (wa[5:3] == 3'b100)
         begin
            scon_reg[wa[2:0]] <= wdata[15:0];
         end
         if (wa[5:3] == 3'b101)
         begin
            fcon_reg[wa[2:0]] <= wdata[15:0];
         end
         if (wa[5:3] == 3'b110)
         begin
            offs_reg[wa[2:0]] <= wdata;
         end
         if (wa[5:3] == 3'b111)
         begin
            gain_reg[wa[2:0]] <= wdata;
         end
      end
   end

   // Active channel brought into the link domain
   always_ff @(posedge sclk or negedge resetn)
   begin
      if (!resetn)
      begin
         tg_s1_reg <= 1'b0;
         tg_s2_reg <= 1'b0;
         tg_s3_reg <= 1'b0;
         seen_chan_reg <= 4'h0;
      end
      else
      begin
         tg_s1_reg <= tgl_reg;
         tg_s2_reg <= tg_s1_reg;
         tg_s3_reg <= tg_s2_reg;
         if (tg_s2_reg != tg_s3_reg)
         begin
            seen_chan_reg <= act_reg;
         end
      end
   end

   // Channel enables as levels into the device domain
   always_comb
   begin
      for (int i = 0; i < 16; i++)
      begin
         chan_on[i] = chan_reg[i][CH_ON_BIT];
      end
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         on_s1_reg <= 16'h0000;
         on_s2_reg <= 16'h0000;
      end
      else
      begin
         on_s1_reg <= chan_on;
         on_s2_reg <= on_s1_reg;
      end
   end

   // Next enabled channel above the current one, wrapping
   always_comb
   begin
      logic found;
      logic [3:0] idx;
      found = 1'b0;
      idx = act_reg;
      act_next = act_reg;
      for (int k = 1; k <= 16; k++)
      begin
         idx = act_reg + 4'(k);
         if (!found && on_s2_reg[idx])
         begin
            act_next = idx;
            found = 1'b1;
         end
      end
   end

   wire any_on = |on_s2_reg;
   wire conv_tick = (conv_cnt_reg == CONV_LAST);

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         conv_cnt_reg <= 10'd0;
         act_reg <= 4'h0;
         tgl_reg <= 1'b0;
         strobe_reg <= 1'b0;
      end
      else
      begin
         conv_cnt_reg <= conv_tick ? 10'd0 : conv_cnt_reg + 10'd1;
         strobe_reg <= conv_tick & any_on;
         if (conv_tick && any_on && (act_next != act_reg))
         begin
            act_reg <= act_next;
            tgl_reg <= ~tgl_reg;
         end
      end
   end

   assign active_channel = act_reg;
   assign conv_strobe = strobe_reg;
endmodule : asr_serial_regs

//--- tb/asr_serial_regs_monitor.sv
module asr_serial_regs_monitor
(
   // Device clock domain
   input wire logic mclk,
   input wire logic resetn,
   input wire logic conv_strobe,
   input wire logic [3:0] active_channel,
   // Serial link
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   input wire logic dout,
   input wire logic dout_oe
);
   import asr_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] cnt;
   logic [7:0] sh;
   // Rising edges seen in this frame and the last eight bits taken
   always_ff @(posedge sclk or posedge cs_n)
   begin
      if (cs_n)
         cnt <= '0;
      else
      begin
         cnt <= (cnt == 8'hFF) ? cnt : cnt + 8'h01;
         sh <= {sh[6:0], din};
      end
   end
   property p_rd_oe;
      @(posedge sclk) disable iff (!resetn || cs_n)
      cnt == 8'h08 && sh[7:6] == 2'b01 |-> dout_oe;
   endproperty
   a_rd_oe: assert property (p_rd_oe) else $error("no read drive");
   property p_gate;
      @(posedge sclk) disable iff (!resetn || cs_n)
      cnt == 8'h08 && sh[7] |-> !dout_oe;
   endproperty
   a_gate: assert property (p_gate) else $error("bad command taken");
   property p_wr_quiet;
      @(posedge sclk) disable iff (!resetn || cs_n)
      cnt == 8'h08 && !sh[6] |-> !dout_oe [*8];
   endproperty
   a_wr_quiet: assert property (p_wr_quiet) else $error("drive in write");
   property p_part_msb;
      @(posedge sclk) disable iff (!resetn || cs_n)
      cnt == 8'h08 && sh == 8'h47 |->
         dout == PART_CODE[15] ##1 dout == PART_CODE[14];
   endproperty
   a_part_msb: assert property (p_part_msb) else $error("part code");
   property p_cs_idle;
      @(posedge mclk) disable iff (!resetn) cs_n |-> !dout_oe;
   endproperty
   a_cs_idle: assert property (p_cs_idle) else $error("drive deselected");
   property p_pulse;
      @(posedge mclk) disable iff (!resetn) conv_strobe |=> !conv_strobe;
   endproperty
   a_pulse: assert property (p_pulse) else $error("long strobe");
   property p_chan_move;
      @(posedge mclk) disable iff (!resetn)
      $changed(active_channel) |-> conv_strobe || $past(conv_strobe);
   endproperty
   a_chan_move: assert property (p_chan_move) else $error("stray move");
   property p_rst_chan;
      @(posedge mclk) disable iff (!resetn)
      $rose(resetn) |-> active_channel == 4'h0;
   endproperty
   a_rst_chan: assert property (p_rst_chan) else $error("reset channel");
endmodule : asr_serial_regs_monitor

bind asr_serial_regs asr_serial_regs_monitor asr_serial_regs_monitor_i
   (.mclk(mclk), .resetn(resetn), .conv_strobe(conv_strobe),
   .active_channel(active_channel), .sclk(sclk), .cs_n(cs_n),
   .din(din), .dout(dout), .dout_oe(dout_oe));

//--- tb/asr_host.sv
module asr_host
(
   // Serial link
   output logic sclk,
   output logic cs_n,
   output logic din,
   input wire logic dout
);
   timeunit 1ns;
   timeprecision 100ps;
   initial
   begin
      sclk = 1'b1;
      cs_n = 1'b1;
      din = 1'b1;
   end
   // One frame, MSB first; clock stands high outside frames
   task automatic shift(input logic [63:0] w, input int n,
      output logic [31:0] r);
      r = '0;
      cs_n = 1'b0;
      for (int i = n - 1; i >= 0; i--)
      begin
         #7.5 sclk = 1'b0;
         din = w[i];
         #7.5 sclk = 1'b1;
         r = {r[30:0], dout};
      end
      #7.5 cs_n = 1'b1;
      din = ~din;
      // Deselect gap so the next frame never meets this release
      #7.5;
   endtask : shift
endmodule : asr_host

//--- tb/tb_asr_serial_regs.sv
module tb_asr_serial_regs;
   import asr_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk = 1'b0;
   logic resetn = 1'b1;
   logic sclk, cs_n, din, dout, dout_oe, conv_strobe;
   logic [3:0] active_channel, prev;
   logic [31:0] rd;
   logic [23:0] v, v0, exp_q[$];
   logic [5:0] rst_a[6] = '{A_CHAN, A_SCON, A_FCON, A_ADCMODE, A_IFMODE,
      A_OFFS};
   logic [23:0] rst_v[6] = '{24'(CHAN0_RST), 24'(SCON_RST), 24'(FCON_RST),
      24'(ADCMODE_RST), 24'(IFMODE_RST), OFFS_RST};
   // Setup word with both input buffers on, coding bit kept
   localparam logic [23:0] SCON_INBUF = 24'h00_1300;
   int err_count, tests_run, cyc, seed = 43;
   `define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
      err_count++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
      end end
   always #5 mclk = ~mclk;
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         err_count++;
         conclude();
      end
   end
   asr_host asr_host_i (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
   asr_serial_regs asr_serial_regs_i (.mclk(mclk), .resetn(resetn),
      .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe),
      .active_channel(active_channel), .conv_strobe(conv_strobe));
   function automatic int wid(logic [5:0] a);
      if (a >= A_OFFS)
         return 24;
      return (a >= A_CHAN || a inside {A_ADCMODE, A_IFMODE, A_PART}) ? 16 : 8;
   endfunction : wid
   function automatic logic [23:0] msk(logic [5:0] a);
      return a < A_SCON ? 24'h00_F3FF : a < A_FCON ? 24'h00_1F30 : '1;
   endfunction : msk
   function automatic logic [3:0] nxt(logic [15:0] m, logic [3:0] c);
      for (int i = 1; i <= 16; i++)
         if (m[4'(c + i)])
            return 4'(c + i);
      return c;
   endfunction : nxt
   task automatic acc(logic [5:0] a, logic r, logic [23:0] w);
      int n;
      n = wid(a);
      asr_host_i.shift((64'({1'b0, r, a}) << n) | 64'(w & msk(a)), n + 8,
         rd);
      rd = rd & 32'((64'h1 << n) - 1);
   endtask : acc
   task automatic conclude;
      $display("tests %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : conclude
   initial
   begin
      #1 resetn = 1'b0;
      repeat (16) @(negedge mclk);
      resetn = 1'b1;
      #100;
      foreach (rst_a[i])
      begin
         acc(rst_a[i], 1'b1, '0);
         `CHK("reset", rst_v[i], rd[23:0])
      end
      acc(A_PART, 1'b0, '0);
      acc(A_PART, 1'b1, '0);
      `CHK("part", PART_CODE[15:4], rd[15:4])
      $display("reset values done");
      for (int p = 0; p < 2; p++)
         for (int a = A_CHAN; a < 64; a++)
         begin
            if (a == A_FCON)
               a = A_GAIN;
            if (p == 0)
               v = 24'($random(seed)) & msk(6'(a));
            if (p == 0)
               exp_q.push_back(v);
            else
               v = exp_q.pop_front();
            if (a == A_CHAN)
               v0 = v;
            acc(6'(a), p[0], p[0] ? '0 : v);
            if (p == 1)
               `CHK("reg", v, rd[23:0])
         end
      $display("random access done");
      asr_host_i.shift({8'h10, 8'h00}, 16, rd);
      asr_host_i.shift({8'h90, 8'h50, 16'h0000}, 32, rd);
      `CHK("abort", v0[15:0], rd[15:0])
      asr_host_i.shift('1, 64, rd);
      acc(A_CHAN, 1'b1, '0);
      `CHK("ones reset", CHAN0_RST, rd[15:0])
      $display("abort and reset done");
      acc(A_SCON, 1'b0, SCON_INBUF);
      acc(A_SCON, 1'b1, '0);
      `CHK("buffers", SCON_INBUF, rd[23:0])
      acc(A_CHAN + 6'h03, 1'b0, 24'h00_8000);
      acc(A_CHAN + 6'h05, 1'b0, 24'h00_8000);
      for (int k = 0; k < 6; k++)
      begin
         @(posedge mclk iff conv_strobe);
         repeat (2) @(negedge mclk);
         if (k > 0)
            `CHK("channel", nxt(16'h0029, prev), active_channel)
         prev = active_channel;
      end
      acc(A_STATUS, 1'b1, '0);
      `CHK("status", {4'h0, prev}, rd[7:0])
      $display("sequencer done");
      conclude();
   end
endmodule : tb_asr_serial_regs
